/* verilog/kbl_consts.svh */
`ifndef KBL_CONSTS_SVH
`define KBL_CONSTS_SVH
`define KBL_WORD_BITS       9
`define KBL_DATA_BITS       8
`define KBL_STOP_POS        8
`define KBL_STOP_LEVEL      1'b1
`define KBL_STATE_BIT       7
`define KBL_KEY_MSB         6
`define KBL_FIFO_DEPTH      16
`define KBL_ACK_HOLD_NS     1000
`define KBL_CLK_PERIOD_NS   10
`define KBL_ACK_HOLD_CYC    ((`KBL_ACK_HOLD_NS + `KBL_CLK_PERIOD_NS - 1) / `KBL_CLK_PERIOD_NS)
`define KBL_HOLDOFF_LEVEL   12
`endif

/* verilog/kbl_pkg.sv */
`default_nettype none
package kbl_pkg;
  typedef struct packed {
    logic       closed;
    logic [6:0] key;
  } kbl_event_s;
  typedef enum logic [1:0] {
    KBL_IDLE = 2'b00,
    KBL_ACK  = 2'b01,
    KBL_REL  = 2'b10
  } kbl_state_e;
endpackage
`default_nettype wire

/* verilog/kbl_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module kbl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             CLOCK_IN,
  input  wire logic             RESET_N_IN,
  input  wire logic             IN_VALID_IN,
  output logic                  IN_READY_OUT,
  input  wire logic [WIDTH-1:0] IN_DATA_IN,
  output logic                  OUT_VALID_OUT,
  input  wire logic             OUT_READY_IN,
  output logic [WIDTH-1:0]      OUT_DATA_OUT,
  output logic [$clog2(DEPTH):0] LEVEL_OUT
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
  end
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wr_r, wr_nxt, rd_r, rd_nxt;
  logic [WIDTH-1:0] dout_r, dout_nxt;
  logic             oval_r, oval_nxt;
  logic             push, pop, load;
  logic [AW:0]      count;

  // Output register counts as a slot in front of memory
  always_comb begin
    count         = wr_r - rd_r;
    IN_READY_OUT  = (count != (AW+1)'(DEPTH));
    push          = IN_VALID_IN && IN_READY_OUT;
    pop           = oval_r && OUT_READY_IN;
    load          = (count != '0) && (!oval_r || pop);
    wr_nxt        = push ? wr_r + 1'b1 : wr_r;
    rd_nxt        = load ? rd_r + 1'b1 : rd_r;
    dout_nxt      = load ? mem_r[rd_r[AW-1:0]] : dout_r;
    oval_nxt      = load ? 1'b1 : (pop ? 1'b0 : oval_r);
    OUT_VALID_OUT = oval_r;
    OUT_DATA_OUT  = dout_r;
    LEVEL_OUT     = count + {{AW{1'b0}}, oval_r};
  end

  always_ff @(posedge CLOCK_IN) begin
    if (push) begin
      mem_r[wr_r[AW-1:0]] <= IN_DATA_IN;
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      wr_r   <= '0;
      rd_r   <= '0;
      dout_r <= '0;
      oval_r <= 1'b0;
    end else begin
      wr_r   <= wr_nxt;
      rd_r   <= rd_nxt;
      dout_r <= dout_nxt;
      oval_r <= oval_nxt;
    end
  end
endmodule // kbl_fifo
`default_nettype wire

/* verilog/kbl_receiver.sv */
// Summary of operation
// - Every link transfer is one nine-bit serial word; receiver frames on nine.
// - Ninth bit is a stop bit, a terminator, never data.
// - Top data bit decodes as key closed versus key open.
// - Low seven data bits are the key number, unencoded.
// - Three control lines; one carries word bits serially toward processor.
// - Processor answers on acknowledge line after taking each bit; code gives no acknowledge to a bad stop bit.
// - Hold-off state as the queue nears full lets processor finish without loss.
`timescale 1ns/1ps
`default_nettype none
`include "kbl_consts.svh"
module kbl_receiver
  import kbl_pkg::*;
#(
  parameter int FIFO_DEPTH   = `KBL_FIFO_DEPTH,
  parameter int HOLDOFF_LVL  = `KBL_HOLDOFF_LEVEL,
  parameter int ACK_HOLD_CYC = `KBL_ACK_HOLD_CYC
) (
  input  wire logic  CLOCK_IN,
  input  wire logic  RESET_N_IN,
  input  wire logic  KB_DATA_IN,
  input  wire logic  KB_READY_IN,
  output logic       KB_ACK_OUT,
  output logic       HOLDOFF_OUT,
  output logic       EVT_VALID_OUT,
  input  wire logic  EVT_READY_IN,
  output kbl_event_s EVT_OUT,
  output logic       FRAME_ERR_OUT,
  output logic       OVERRUN_OUT
);
  initial begin
    if (HOLDOFF_LVL < 1 || HOLDOFF_LVL > FIFO_DEPTH) $error("Bad HOLDOFF_LVL");
    if (ACK_HOLD_CYC < 1 || ACK_HOLD_CYC > 255) $error("Bad ACK_HOLD_CYC");
  end

  localparam int LW       = $clog2(FIFO_DEPTH) + 1;
  localparam int HW       = 8;
  localparam int NPIN     = 2;
  localparam int PIN_DATA = 0;
  localparam int PIN_RDY  = 1;

  initial begin
    if ((1 << (LW - 1)) != FIFO_DEPTH) $error("FIFO_DEPTH must be a power of two");
    if ($bits(kbl_event_s) != `KBL_DATA_BITS) $error("Event must fill the data byte");
    if (`KBL_STOP_POS != `KBL_WORD_BITS - 1) $error("Stop bit must close the word");
    if (`KBL_WORD_BITS > 15) $error("Bit counter too narrow for the word");
    if (`KBL_STATE_BIT != `KBL_DATA_BITS - 1) $error("State bit must be the top bit");
    if (`KBL_KEY_MSB != `KBL_STATE_BIT - 1) $error("Key field must sit below state");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  function automatic kbl_event_s decode_byte(input logic [`KBL_DATA_BITS-1:0] b);
    kbl_event_s e;
    e.closed = b[`KBL_STATE_BIT];
    e.key    = b[`KBL_KEY_MSB:0];
    return e;
  endfunction

  // Word position that carries the stop bit
  function automatic logic at_stop(input logic [3:0] pos);
    return pos == 4'(`KBL_STOP_POS);
  endfunction

  // Stop bit at its defined level
  function automatic logic stop_good(input logic b);
    return b == `KBL_STOP_LEVEL;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, two stages per pin

  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_meta_r;
  logic [NPIN-1:0] pin_sync_r;
  logic            data_s;
  logic            rdy_s;

  assign pin_raw[PIN_DATA] = KB_DATA_IN;
  assign pin_raw[PIN_RDY]  = KB_READY_IN;

  // Reset to the idle pin level, so no false ready
  generate
    for (genvar g = 0; g < NPIN; g++) begin : g_sync
      always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
          pin_meta_r[g] <= 1'b0;
          pin_sync_r[g] <= 1'b0;
        end else begin
          pin_meta_r[g] <= pin_raw[g];
          pin_sync_r[g] <= pin_meta_r[g];
        end
      end
    end
  endgenerate

  // Logic reads the second stage only
  assign data_s = pin_sync_r[PIN_DATA];
  assign rdy_s  = pin_sync_r[PIN_RDY];

  ////////////////////////////////////////////////////////////////////////////
  // State of the link side

  // Handshake
  kbl_state_e    st_r;
  kbl_state_e    st_nxt;
  logic [HW-1:0] hold_r;
  logic [HW-1:0] hold_nxt;
  logic          ack_r;
  logic          ack_nxt;

  // Word assembly
  logic [3:0]    bit_r;
  logic [3:0]    bit_nxt;
  logic [7:0]    sh_r;
  logic [7:0]    sh_nxt;

  // Status pulses and hold-off
  logic          ferr_r;
  logic          ferr_nxt;
  logic          ovr_r;
  logic          ovr_nxt;
  logic          holdoff_r;
  logic          holdoff_nxt;

  // Strobes and queue side
  logic          take_bit;
  logic          take_stop;
  logic          stop_ok;
  logic          push;
  kbl_event_s    push_data;
  logic          fifo_ready;
  logic [LW-1:0] level;

  // A bit is taken only from idle
  always_comb begin
    take_bit  = (st_r == KBL_IDLE) && rdy_s;
    take_stop = take_bit && at_stop(bit_r);
    // Level check matters only with take_stop
    stop_ok   = stop_good(data_s);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit handshake
  // Ack stands ACK_HOLD_CYC cycles at least, then until ready drops

  always_comb begin
    st_nxt   = st_r;
    hold_nxt = hold_r;
    ack_nxt  = ack_r;
    unique case (st_r)
      KBL_IDLE: begin
        if (take_bit) begin
          if (take_stop && !stop_ok) begin
            // No acknowledge; keyboard times out and resends
            st_nxt = KBL_REL;
          end else begin
            ack_nxt  = 1'b1;
            hold_nxt = HW'(ACK_HOLD_CYC);
            st_nxt   = KBL_ACK;
          end
        end
      end
      KBL_ACK: begin
        // Minimum hold counts down first
        if (hold_r != '0) begin
          hold_nxt = hold_r - HW'(1);
        end else if (!rdy_s) begin
          ack_nxt = 1'b0;
          st_nxt  = KBL_IDLE;
        end
      end
      KBL_REL: begin
        // Wait for ready to fall before the resend
        if (!rdy_s) begin
          st_nxt = KBL_IDLE;
        end
      end
      default: begin
        ack_nxt = 1'b0;
        st_nxt  = KBL_IDLE;
      end
    endcase
  end

  // Handshake registers
  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      st_r   <= KBL_IDLE;
      hold_r <= '0;
      ack_r  <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      hold_r <= hold_nxt;
      ack_r  <= ack_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Word assembly, least significant bit first

  always_comb begin
    bit_nxt = bit_r;
    sh_nxt  = sh_r;
    // Counter restarts on any stop, good or bad
    if (take_stop) begin
      bit_nxt = 4'h0;
    end else if (take_bit) begin
      sh_nxt  = {data_s, sh_r[7:1]};
      bit_nxt = bit_r + 4'h1;
    end
  end

  // Assembly registers
  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      bit_r <= 4'h0;
      sh_r  <= 8'h0;
    end else begin
      bit_r <= bit_nxt;
      sh_r  <= sh_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event hand-off and status pulses

  always_comb begin
    push      = take_stop && stop_ok;
    push_data = decode_byte(sh_r);
    // Bad stop: word discarded
    ferr_nxt  = take_stop && !stop_ok;
    // Full queue: word still acknowledged, then dropped
    ovr_nxt   = push && !fifo_ready;
  end

  // Status registers
  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      ferr_r <= 1'b0;
      ovr_r  <= 1'b0;
    end else begin
      ferr_r <= ferr_nxt;
      ovr_r  <= ovr_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hold-off while the queue is nearly full

  always_comb begin
    holdoff_nxt = (level >= LW'(HOLDOFF_LVL));
  end

  // Hold-off register
  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      holdoff_r <= 1'b0;
    end else begin
      holdoff_r <= holdoff_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event queue
  // Holds events until the consumer takes them

  kbl_fifo #(
    .WIDTH ($bits(kbl_event_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .CLOCK_IN      (CLOCK_IN),
    .RESET_N_IN    (RESET_N_IN),
    .IN_VALID_IN   (push),
    .IN_READY_OUT  (fifo_ready),
    .IN_DATA_IN    (push_data),
    .OUT_VALID_OUT (EVT_VALID_OUT),
    .OUT_READY_IN  (EVT_READY_IN),
    .OUT_DATA_OUT  (EVT_OUT),
    .LEVEL_OUT     (level)
  );


  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Link side
  assign KB_ACK_OUT    = ack_r;
  assign HOLDOFF_OUT   = holdoff_r;

  // Status side
  assign FRAME_ERR_OUT = ferr_r;
  assign OVERRUN_OUT   = ovr_r;
endmodule // kbl_receiver
`default_nettype wire

/* tb/kbl_receiver_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module kbl_receiver_chk
  import kbl_pkg::*;
(
  input wire logic       CLOCK_IN,
  input wire logic       RESET_N_IN,
  input wire logic       KB_DATA_IN,
  input wire logic       KB_READY_IN,
  input wire logic       KB_ACK_OUT,
  input wire logic       HOLDOFF_OUT,
  input wire logic       EVT_VALID_OUT,
  input wire logic       EVT_READY_IN,
  input wire kbl_event_s EVT_OUT,
  input wire logic       FRAME_ERR_OUT,
  input wire logic       OVERRUN_OUT
);
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RESET_N_IN);
  property p_ack_cause; $rose(KB_ACK_OUT) |-> $past(KB_READY_IN, 2); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without ready");
  property p_ack_hold; $fell(KB_ACK_OUT) |-> $past(KB_ACK_OUT, 2); endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack too short");
  property p_ack_rel; $fell(KB_ACK_OUT) |-> !$past(KB_READY_IN) && !$past(KB_READY_IN, 2); endproperty
  a_ack_rel: assert property (p_ack_rel) else $error("ack dropped early");
  property p_frame; FRAME_ERR_OUT |-> !KB_ACK_OUT && !$past(KB_DATA_IN, 2); endproperty
  a_frame: assert property (p_frame) else $error("bad frame flag");
  property p_err_pulse; FRAME_ERR_OUT |=> !FRAME_ERR_OUT; endproperty
  a_err_pulse: assert property (p_err_pulse) else $error("frame flag long");
  property p_ovr_pulse; OVERRUN_OUT |=> !OVERRUN_OUT; endproperty
  a_ovr_pulse: assert property (p_ovr_pulse) else $error("overrun long");
  property p_ovr_hold; OVERRUN_OUT |-> HOLDOFF_OUT; endproperty
  a_ovr_hold: assert property (p_ovr_hold) else $error("overrun w/o holdoff");
  property p_evt; EVT_VALID_OUT && !EVT_READY_IN |=> EVT_VALID_OUT && $stable(EVT_OUT); endproperty
  a_evt: assert property (p_evt) else $error("event not held");
endmodule // kbl_receiver_chk
bind kbl_receiver kbl_receiver_chk i_chk (.*);
`default_nettype wire

/* tb/kbl_keyboard_model.sv */
`timescale 1ns/1ps
`default_nettype none
module kbl_keyboard_model (
  input  wire logic CLOCK_IN,
  input  wire logic KB_ACK_IN,
  input  wire logic HOLDOFF_IN,
  output logic      KB_DATA_OUT,
  output logic      KB_READY_OUT
);
  logic [8:0] q[$];
  logic [8:0] w;
  bit         ok;
  bit         ok2;
  initial KB_DATA_OUT = 1'b0;
  initial KB_READY_OUT = 1'b0;
  task automatic hs(input logic v, output bit got);
    got = 0;
    repeat (40) begin
      @(posedge CLOCK_IN);
      if (KB_ACK_IN === v) begin
        got = 1;
        break;
      end
    end
  endtask
  always begin
    @(posedge CLOCK_IN);
    if (q.size() != 0 && HOLDOFF_IN !== 1'b1) begin
      w = q[0];
      for (int i = 0; i < 9; i++) begin
        KB_DATA_OUT  <= w[i];
        KB_READY_OUT <= 1'b1;
        hs(1'b1, ok);
        KB_READY_OUT <= 1'b0;
        KB_DATA_OUT  <= ~w[i];
        hs(1'b0, ok2);
        if (!ok) break;
      end
      // Failed word resent whole, line glitch gone
      if (ok) void'(q.pop_front());
      else q[0][8] = 1'b1;
    end
  end
endmodule // kbl_keyboard_model
`default_nettype wire

/* tb/kbl_receiver_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fails++; \
  $display("unexpected %0t got %h want %h", $time, a, e); end end
module kbl_receiver_bench
  import kbl_pkg::*;
;
  logic       clk = 0;
  logic       rst_n = 0;
  logic       kb_data;
  logic       kb_ready;
  logic       ack;
  logic       hold;
  logic       valid;
  logic       ferr;
  logic       ovr;
  logic       rdy = 0;
  kbl_event_s evt;
  int         fails = 0;
  int         checks_done = 0;
  int         cyc = 0;
  int         nerr = 0;
  int         novr = 0;
  logic [15:0] rows [4] = '{16'h0000, 16'hffff, 16'h8080, 16'h2a2a};
  always #5 clk = ~clk;
  kbl_receiver #(.ACK_HOLD_CYC(2)) i_dut (.CLOCK_IN(clk), .RESET_N_IN(rst_n),
    .KB_DATA_IN(kb_data), .KB_READY_IN(kb_ready), .KB_ACK_OUT(ack), .HOLDOFF_OUT(hold),
    .EVT_VALID_OUT(valid), .EVT_READY_IN(rdy), .EVT_OUT(evt), .FRAME_ERR_OUT(ferr),
    .OVERRUN_OUT(ovr));
  kbl_keyboard_model i_kb (.CLOCK_IN(clk), .KB_ACK_IN(ack), .HOLDOFF_IN(hold),
    .KB_DATA_OUT(kb_data), .KB_READY_OUT(kb_ready));
  task automatic tally_and_finish();
    if (fails == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic take(input logic [7:0] e);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (valid !== 1'b1 && n < 3000);
    `CHK(evt, e)
    @(posedge clk) rdy <= 1'b1;
    @(posedge clk) rdy <= 1'b0;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (ferr === 1'b1) nerr <= nerr + 1;
    if (ovr === 1'b1) novr <= novr + 1;
    if (cyc == 20000) begin
      fails++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    `CHK({ack, hold, valid, ferr, ovr}, 5'h00)
    @(posedge clk) rst_n <= 1'b1;
    foreach (rows[i]) i_kb.q.push_back({1'b1, rows[i][15:8]});
    foreach (rows[i]) take(rows[i][7:0]);
    i_kb.q.push_back(9'h03c);
    take(8'h3c);
    `CHK(nerr, 1)
    for (int i = 0; i < 18; i++) i_kb.q.push_back({1'b1, 8'(i)});
    repeat (2500) @(posedge clk);
    @(negedge clk);
    `CHK({hold, i_kb.q.size() > 0}, 2'b11)
    for (int i = 0; i < 18; i++) take(8'(i));
    @(negedge clk);
    `CHK(novr, 0)
    `CHK({valid, hold}, 2'b00)
    tally_and_finish();
  end
endmodule // kbl_receiver_bench
`default_nettype wire
